// [fss_pkg.sv]
package fss_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int PRESET_W = 16;
	localparam int EFF_W = 18;
	localparam int SP_W = 20;
	localparam int NUM_PRESETS = 16;
	localparam int NUM_SEL = 4;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_PRESET_BASE = 8'h00;
	localparam logic [7:0] OFF_PRESET_LAST = 8'h3c;
	localparam logic [7:0] OFF_MODE = 8'h40;
	localparam logic [7:0] OFF_SEL_SRC = 8'h44;
	localparam logic [7:0] OFF_DIR_CTRL = 8'h48;
	localparam logic [7:0] OFF_STATUS = 8'h4c;
	localparam logic [7:0] OFF_EFFECTIVE = 8'h50;
	localparam logic [7:0] OFF_SETPOINT = 8'h54;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int SRC_W = 6;
	localparam int POS_SEL_SRC0 = 0;
	localparam int POS_INV_SRC = 0;
	localparam int POS_POS_SRC = 8;
	localparam int POS_NEG_SRC = 16;
	localparam int POS_MAIN_SRC = 24;
	localparam int POS_EXTRA_SRC = 26;
	localparam int POS_FLAG = 0;
	localparam int POS_INV_ACT = 1;
	localparam int POS_POS_BLK = 2;
	localparam int POS_NEG_BLK = 3;

	// ----------------------------------------
	// Encodings and reset values
	// ----------------------------------------
	localparam logic [1:0] MODE_DIRECT = 2'h1;
	localparam logic [1:0] MODE_BINARY = 2'h2;
	localparam logic [1:0] RST_MODE = MODE_DIRECT;
	localparam logic [1:0] KIND_ZERO = 2'h0;
	localparam logic [1:0] KIND_ONE = 2'h1;
	localparam logic [1:0] KIND_DI = 2'h2;
	localparam logic [1:0] KIND_CW = 2'h3;
	localparam logic [1:0] SPSRC_ZERO = 2'h0;
	localparam logic [1:0] SPSRC_FIXED = 2'h1;
	localparam logic [1:0] SPSRC_EXT = 2'h2;
	localparam logic [1:0] RST_MAIN_SRC = SPSRC_FIXED;
	localparam logic [1:0] RST_EXTRA_SRC = SPSRC_ZERO;
	localparam logic [PRESET_W-1:0] RST_PRESET = 16'h0000;
	localparam logic [1:0] DIRECT_LAST_STEP = 2'h3;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [1:0] kind;
		logic [3:0] idx;
	} fss_src_t;

	localparam fss_src_t RST_SRC = '{kind: KIND_ZERO, idx: 4'h0};

	typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_DONE} fss_scan_t;

	typedef struct packed {
		logic [1:0] mode;
		fss_src_t [NUM_SEL-1:0] sel_src;
		fss_src_t inv_src;
		fss_src_t pos_src;
		fss_src_t neg_src;
		logic [1:0] main_src;
		logic [1:0] extra_src;
		fss_scan_t scan;
		logic [1:0] step;
		logic [1:0] snap_mode;
		logic [NUM_SEL-1:0] snap_sel;
		logic tag_vld;
		logic [1:0] tag_step;
		logic signed [EFF_W-1:0] acc;
		logic signed [EFF_W-1:0] eff;
		logic flag;
		logic rd_mem;
		logic [31:0] rdata;
	} fss_state_t;

	typedef struct packed {
		logic [NUM_PRESETS-1:0][PRESET_W-1:0] word;
		logic [PRESET_W-1:0] bus_q;
		logic [PRESET_W-1:0] scan_q;
	} fss_mem_state_t;

	typedef struct packed {
		logic signed [SP_W-1:0] sp;
		logic pos_clamp;
		logic neg_clamp;
	} fss_proc_state_t;

	// Source decoder shared by every selectable binary input
	function automatic logic src_bit(input fss_src_t s, input logic [15:0] di, input logic [15:0] cw);
		logic b;
		b = 1'b0;
		case (s.kind)
			KIND_ZERO: b = 1'b0;
			KIND_ONE: b = 1'b1;
			KIND_DI: b = di[s.idx];
			KIND_CW: b = cw[s.idx];
			default: b = 1'b0;
		endcase
		return b;
	endfunction : src_bit

endpackage : fss_pkg

// [fss_preset_mem.sv]
`timescale 1ns/1ps
module fss_preset_mem (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [3:0] wr_addr,
	input wire logic [fss_pkg::PRESET_W-1:0] wr_data,
	input wire logic [3:0] bus_addr,
	output logic [fss_pkg::PRESET_W-1:0] bus_rdata,
	input wire logic [3:0] scan_addr,
	output logic [fss_pkg::PRESET_W-1:0] scan_rdata
);
	fss_pkg::fss_mem_state_t s_q, s_d;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// Entry 0 is the empty selection and stays zero
	always_comb begin
		s_d = s_q;
		for (int i = 1; i < fss_pkg::NUM_PRESETS; i++) begin
			if (wr_en && wr_addr == 4'(i)) begin
				s_d.word[i] = wr_data;
			end
		end
		s_d.word[0] = fss_pkg::RST_PRESET;
		s_d.bus_q = s_q.word[bus_addr];
		s_d.scan_q = s_q.word[scan_addr];
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign bus_rdata = s_q.bus_q;
	assign scan_rdata = s_q.scan_q;

endmodule : fss_preset_mem

// [fss_setpoint_proc.sv]
`timescale 1ns/1ps
module fss_setpoint_proc (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic signed [fss_pkg::EFF_W-1:0] fixed_sp,
	input wire logic signed [fss_pkg::PRESET_W-1:0] main_ext_in,
	input wire logic signed [fss_pkg::PRESET_W-1:0] extra_ext_in,
	input wire logic [1:0] main_setpoint_source,
	input wire logic [1:0] extra_setpoint_source,
	input wire logic invert,
	input wire logic pos_block,
	input wire logic neg_block,
	output logic signed [fss_pkg::SP_W-1:0] setpoint_out,
	output logic pos_clamped,
	output logic neg_clamped
);
	fss_pkg::fss_proc_state_t s_q, s_d;
	logic signed [fss_pkg::SP_W-1:0] main_v;
	logic signed [fss_pkg::SP_W-1:0] extra_v;
	logic signed [fss_pkg::SP_W-1:0] sum_v;
	logic signed [fss_pkg::SP_W-1:0] inv_v;

	function automatic logic signed [fss_pkg::SP_W-1:0] pick(input logic [1:0] src,
		input logic signed [fss_pkg::EFF_W-1:0] fx, input logic signed [fss_pkg::PRESET_W-1:0] ext);
		logic signed [fss_pkg::SP_W-1:0] v;
		v = '0;
		case (src)
			fss_pkg::SPSRC_FIXED: v = fss_pkg::SP_W'(fx);
			fss_pkg::SPSRC_EXT: v = fss_pkg::SP_W'(ext);
			default: v = '0;
		endcase
		return v;
	endfunction : pick

	// ----------------------------------------
	// Source, inversion and direction inhibit
	// ----------------------------------------
	always_comb begin
		main_v = pick(main_setpoint_source, fixed_sp, main_ext_in);
		extra_v = pick(extra_setpoint_source, fixed_sp, extra_ext_in);
		sum_v = main_v + extra_v;
		inv_v = invert ? -sum_v : sum_v;
		s_d = s_q;
		s_d.pos_clamp = pos_block && inv_v > 0;
		s_d.neg_clamp = neg_block && inv_v < 0;
		// Clamp rather than mirror: a blocked direction must never reverse the drive
		s_d.sp = (s_d.pos_clamp || s_d.neg_clamp) ? '0 : inv_v;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign setpoint_out = s_q.sp;
	assign pos_clamped = s_q.pos_clamp;
	assign neg_clamped = s_q.neg_clamp;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_neg_block_clamp: assert property (@(posedge sys_clk) disable iff (!rst_n)
		neg_block |=> setpoint_out >= 0) else $error("negative setpoint passed while blocked");
	chk_pos_block_clamp: assert property (@(posedge sys_clk) disable iff (!rst_n)
		pos_block |=> setpoint_out <= 0) else $error("positive setpoint passed while blocked");
	chk_invert_sign: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!pos_block && !neg_block && main_setpoint_source == fss_pkg::SPSRC_EXT
		&& extra_setpoint_source == fss_pkg::SPSRC_ZERO)
		|=> setpoint_out == (($past(invert)) ? -fss_pkg::SP_W'($past(main_ext_in))
		: fss_pkg::SP_W'($past(main_ext_in)))) else $error("inversion result wrong");
	cov_neg_clamp: cover property (@(posedge sys_clk) disable iff (!rst_n) neg_clamped);

endmodule : fss_setpoint_proc

// [fss_selector.sv]
`timescale 1ns/1ps
// Function
// - Direct mode sums presets of asserted inputs
// - Binary mode outputs preset indexed by code
// - Method 1 direct, 2 binary, reset direct
// - Presets 1 to 15 programmable, reset to zero rpm
// - Selection sources default to constant zero
// - Effective setpoint readable as output
// - Status flag high while preset selected
// - Effective speed feeds main and additional paths
// - Inversion input high negates setpoint sign
// - Both directions permitted after reset
// - Negative inhibit high blocks negative rotation
// - Independent positive and negative inhibit controls
module fss_selector (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [15:0] di_in,
	input wire logic [15:0] ctrl_word,
	input wire logic signed [fss_pkg::PRESET_W-1:0] main_ext_in,
	input wire logic signed [fss_pkg::PRESET_W-1:0] extra_ext_in,
	output logic signed [fss_pkg::EFF_W-1:0] preset_speed_effective,
	output logic preset_selected_flag,
	output logic signed [fss_pkg::SP_W-1:0] setpoint_out,
	output logic pos_clamped,
	output logic neg_clamped
);
	fss_pkg::fss_state_t s_q, s_d;
	logic [fss_pkg::NUM_SEL-1:0] sel_live;
	logic inv_live;
	logic pos_live;
	logic neg_live;
	logic wr_preset;
	logic rd_preset;
	logic [3:0] scan_addr;
	logic [fss_pkg::PRESET_W-1:0] mem_bus_rdata;
	logic [fss_pkg::PRESET_W-1:0] mem_scan_rdata;
	logic signed [fss_pkg::EFF_W-1:0] addend;
	logic [31:0] rd_word;

	// ----------------------------------------
	// Binary sources
	// ----------------------------------------
	// Inputs and control word are taken as synchronous, no synchroniser here
	generate
		for (genvar g = 0; g < fss_pkg::NUM_SEL; g++) begin : g_sel
			assign sel_live[g] = fss_pkg::src_bit(s_q.sel_src[g], di_in, ctrl_word);
		end
	endgenerate

	assign inv_live = fss_pkg::src_bit(s_q.inv_src, di_in, ctrl_word);
	assign pos_live = fss_pkg::src_bit(s_q.pos_src, di_in, ctrl_word);
	assign neg_live = fss_pkg::src_bit(s_q.neg_src, di_in, ctrl_word);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	assign wr_preset = reg_wr && reg_addr <= fss_pkg::OFF_PRESET_LAST && reg_addr[1:0] == 2'h0;
	assign rd_preset = reg_rd && reg_addr <= fss_pkg::OFF_PRESET_LAST && reg_addr[1:0] == 2'h0;

	// ----------------------------------------
	// Preset table
	// ----------------------------------------
	fss_preset_mem u_mem (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.wr_en(wr_preset),
		.wr_addr(reg_addr[5:2]),
		.wr_data(reg_wdata[fss_pkg::PRESET_W-1:0]),
		.bus_addr(reg_addr[5:2]),
		.bus_rdata(mem_bus_rdata),
		.scan_addr(scan_addr),
		.scan_rdata(mem_scan_rdata)
	);

	// ----------------------------------------
	// Scan address and addend
	// ----------------------------------------
	always_comb begin
		scan_addr = 4'h0;
		if (s_q.scan == fss_pkg::ST_SCAN) begin
			if (s_q.snap_mode == fss_pkg::MODE_DIRECT) begin
				scan_addr = 4'(s_q.step) + 4'h1;
			end else begin
				scan_addr = s_q.snap_sel;
			end
		end
	end

	always_comb begin
		addend = '0;
		if (s_q.tag_vld) begin
			if (s_q.snap_mode == fss_pkg::MODE_DIRECT) begin
				addend = s_q.snap_sel[s_q.tag_step] ? fss_pkg::EFF_W'($signed(mem_scan_rdata)) : '0;
			end else begin
				addend = fss_pkg::EFF_W'($signed(mem_scan_rdata));
			end
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always_comb begin
		rd_word = 32'h0000_0000;
		case (reg_addr)
			fss_pkg::OFF_MODE: rd_word[1:0] = s_q.mode;
			fss_pkg::OFF_SEL_SRC: begin
				for (int i = 0; i < fss_pkg::NUM_SEL; i++) begin
					rd_word[fss_pkg::POS_SEL_SRC0 + i*fss_pkg::SRC_W +: fss_pkg::SRC_W] = s_q.sel_src[i];
				end
			end
			fss_pkg::OFF_DIR_CTRL: begin
				rd_word[fss_pkg::POS_INV_SRC +: fss_pkg::SRC_W] = s_q.inv_src;
				rd_word[fss_pkg::POS_POS_SRC +: fss_pkg::SRC_W] = s_q.pos_src;
				rd_word[fss_pkg::POS_NEG_SRC +: fss_pkg::SRC_W] = s_q.neg_src;
				rd_word[fss_pkg::POS_MAIN_SRC +: 2] = s_q.main_src;
				rd_word[fss_pkg::POS_EXTRA_SRC +: 2] = s_q.extra_src;
			end
			fss_pkg::OFF_STATUS: begin
				rd_word[fss_pkg::POS_FLAG] = s_q.flag;
				rd_word[fss_pkg::POS_INV_ACT] = inv_live;
				rd_word[fss_pkg::POS_POS_BLK] = pos_live;
				rd_word[fss_pkg::POS_NEG_BLK] = neg_live;
			end
			fss_pkg::OFF_EFFECTIVE: rd_word = 32'(s_q.eff);
			fss_pkg::OFF_SETPOINT: rd_word = 32'(setpoint_out);
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.rd_mem = rd_preset;
		s_d.rdata = (reg_rd && !rd_preset) ? rd_word : 32'h0000_0000;
		s_d.tag_vld = 1'b0;
		if (reg_wr) begin
			case (reg_addr)
				fss_pkg::OFF_MODE: begin
					// Undefined methods are ignored so a stray write cannot stall selection
					if (reg_wdata[1:0] == fss_pkg::MODE_DIRECT || reg_wdata[1:0] == fss_pkg::MODE_BINARY) begin
						s_d.mode = reg_wdata[1:0];
					end
				end
				fss_pkg::OFF_SEL_SRC: begin
					for (int i = 0; i < fss_pkg::NUM_SEL; i++) begin
						s_d.sel_src[i] = reg_wdata[fss_pkg::POS_SEL_SRC0 + i*fss_pkg::SRC_W +: fss_pkg::SRC_W];
					end
				end
				fss_pkg::OFF_DIR_CTRL: begin
					s_d.inv_src = reg_wdata[fss_pkg::POS_INV_SRC +: fss_pkg::SRC_W];
					s_d.pos_src = reg_wdata[fss_pkg::POS_POS_SRC +: fss_pkg::SRC_W];
					s_d.neg_src = reg_wdata[fss_pkg::POS_NEG_SRC +: fss_pkg::SRC_W];
					s_d.main_src = reg_wdata[fss_pkg::POS_MAIN_SRC +: 2];
					s_d.extra_src = reg_wdata[fss_pkg::POS_EXTRA_SRC +: 2];
				end
				default: begin
				end
			endcase
		end
		// Selection is snapshotted so one result never mixes two input states
		case (s_q.scan)
			fss_pkg::ST_IDLE: begin
				s_d.snap_sel = sel_live;
				s_d.snap_mode = s_q.mode;
				s_d.acc = '0;
				s_d.step = 2'h0;
				s_d.scan = fss_pkg::ST_SCAN;
			end
			fss_pkg::ST_SCAN: begin
				s_d.tag_vld = 1'b1;
				s_d.tag_step = s_q.step;
				s_d.acc = s_q.acc + addend;
				s_d.step = s_q.step + 2'h1;
				if (s_q.snap_mode != fss_pkg::MODE_DIRECT || s_q.step == fss_pkg::DIRECT_LAST_STEP) begin
					s_d.scan = fss_pkg::ST_DONE;
				end
			end
			fss_pkg::ST_DONE: begin
				s_d.eff = s_q.acc + addend;
				s_d.flag = |s_q.snap_sel;
				s_d.scan = fss_pkg::ST_IDLE;
			end
			default: s_d.scan = fss_pkg::ST_IDLE;
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.mode <= fss_pkg::RST_MODE;
			s_q.sel_src <= {fss_pkg::NUM_SEL{fss_pkg::RST_SRC}};
			s_q.inv_src <= fss_pkg::RST_SRC;
			s_q.pos_src <= fss_pkg::RST_SRC;
			s_q.neg_src <= fss_pkg::RST_SRC;
			s_q.main_src <= fss_pkg::RST_MAIN_SRC;
			s_q.extra_src <= fss_pkg::RST_EXTRA_SRC;
			s_q.scan <= fss_pkg::ST_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rd_mem ? 32'(mem_bus_rdata) : s_q.rdata;
	assign preset_speed_effective = s_q.eff;
	assign preset_selected_flag = s_q.flag;

	// ----------------------------------------
	// Setpoint processing
	// ----------------------------------------
	fss_setpoint_proc u_proc (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.fixed_sp(s_q.eff),
		.main_ext_in(main_ext_in),
		.extra_ext_in(extra_ext_in),
		.main_setpoint_source(s_q.main_src),
		.extra_setpoint_source(s_q.extra_src),
		.invert(inv_live),
		.pos_block(pos_live),
		.neg_block(neg_live),
		.setpoint_out(setpoint_out),
		.pos_clamped(pos_clamped),
		.neg_clamped(neg_clamped)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_mode_bad_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(reg_wr && reg_addr == fss_pkg::OFF_MODE && reg_wdata[1:0] != fss_pkg::MODE_DIRECT
		&& reg_wdata[1:0] != fss_pkg::MODE_BINARY) |=> s_q.mode == $past(s_q.mode))
		else $error("mode took an undefined value");
	chk_mode_legal: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_q.mode == fss_pkg::MODE_DIRECT || s_q.mode == fss_pkg::MODE_BINARY)
		else $error("mode register illegal");
	chk_direct_empty: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s_q.scan == fss_pkg::ST_DONE && s_q.snap_mode == fss_pkg::MODE_DIRECT && s_q.snap_sel == 4'h0)
		|=> preset_speed_effective == 0 && !preset_selected_flag) else $error("empty selection not zero");
	chk_flag_tracks: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_q.scan == fss_pkg::ST_DONE |=> preset_selected_flag == ($past(s_q.snap_sel) != 4'h0))
		else $error("status flag wrong");
	chk_source_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_q.sel_src[0].kind == fss_pkg::KIND_ZERO |-> !sel_live[0]) else $error("zero source asserted");
	chk_eff_readback: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(reg_rd && reg_addr == fss_pkg::OFF_EFFECTIVE) |=> reg_rdata == 32'($past(s_q.eff)))
		else $error("effective readback wrong");
	chk_preset_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(reg_rd && reg_addr == fss_pkg::OFF_PRESET_BASE) |=> reg_rdata == 32'h0000_0000)
		else $error("empty preset entry not zero");
	chk_direct_steps: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s_q.scan == fss_pkg::ST_IDLE && s_q.mode == fss_pkg::MODE_DIRECT)
		|=> s_q.scan == fss_pkg::ST_SCAN [*4] ##1 s_q.scan == fss_pkg::ST_DONE)
		else $error("direct scan length wrong");
	chk_binary_steps: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s_q.scan == fss_pkg::ST_IDLE && s_q.mode == fss_pkg::MODE_BINARY)
		|=> s_q.scan == fss_pkg::ST_SCAN ##1 s_q.scan == fss_pkg::ST_DONE)
		else $error("binary scan length wrong");
	chk_publish_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_q.scan == fss_pkg::ST_IDLE |-> ##[2:5] s_q.scan == fss_pkg::ST_DONE)
		else $error("effective update late");
	chk_rdata_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!reg_rd |=> reg_rdata == 32'h0000_0000) else $error("read data outside read slot");

	cov_direct_two: cover property (@(posedge sys_clk) disable iff (!rst_n)
		s_q.scan == fss_pkg::ST_DONE && s_q.snap_mode == fss_pkg::MODE_DIRECT && s_q.snap_sel == 4'h3);
	cov_binary_sel: cover property (@(posedge sys_clk) disable iff (!rst_n)
		s_q.scan == fss_pkg::ST_DONE && s_q.snap_mode == fss_pkg::MODE_BINARY && s_q.snap_sel == 4'hf);
	cov_inverted: cover property (@(posedge sys_clk) disable iff (!rst_n) inv_live && setpoint_out != 0);

endmodule : fss_selector

// [fss_input_model.sv]
`timescale 1ns/1ps
module fss_input_model (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [15:0] di_req,
	input wire logic [15:0] cw_req,
	output logic [15:0] di_in,
	output logic [15:0] ctrl_word
);
	// ----------------------------------------
	// Terminal and fieldbus levels
	// ----------------------------------------
	// Registered, so a level lands one edge after the request, as a filtered input stage would
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			di_in <= 16'h0000;
			ctrl_word <= 16'h0000;
		end else begin
			di_in <= di_req;
			ctrl_word <= cw_req;
		end
	end
endmodule : fss_input_model

// [fixed_setpoint_selector_tb_top.sv]
`timescale 1ns/1ps
module fixed_setpoint_selector_tb_top;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h00000000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [15:0] di_req = 16'h0000;
	logic [15:0] cw_req = 16'h0000;
	logic [15:0] di_in;
	logic [15:0] ctrl_word;
	logic signed [fss_pkg::PRESET_W-1:0] main_ext_in = 16'h0000;
	logic signed [fss_pkg::PRESET_W-1:0] extra_ext_in = 16'h0000;
	logic signed [fss_pkg::EFF_W-1:0] eff;
	logic flag;
	logic signed [fss_pkg::SP_W-1:0] sp;
	logic pos_clamped;
	logic neg_clamped;
	int mismatches = 0;
	int total_checks = 0;
	int preset [16];

	always #50 sys_clk = ~sys_clk;

	fss_input_model u_src (.sys_clk(sys_clk), .rst_n(rst_n), .di_req(di_req), .cw_req(cw_req),
		.di_in(di_in), .ctrl_word(ctrl_word));

	fss_selector DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .di_in(di_in), .ctrl_word(ctrl_word),
		.main_ext_in(main_ext_in), .extra_ext_in(extra_ext_in), .preset_speed_effective(eff),
		.preset_selected_flag(flag), .setpoint_out(sp), .pos_clamped(pos_clamped), .neg_clamped(neg_clamped));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic ok, input string msg);
		total_checks++;
		if (!ok) begin
			mismatches++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask : check

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : reg_write

	// Read data stand only in the cycle after the strobe, so sample mid-cycle there
	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		d = reg_rdata;
	endtask : reg_read

	// Covers two scan periods plus the input and output stages
	task automatic settle();
		repeat (24) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask : settle

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_reset();
		logic [31:0] d;
		reg_read(8'h40, d);
		check(d === 32'h00000001, "mode not direct after reset");
		reg_read(8'h08, d);
		check(d === 32'h00000000, "preset not zero after reset");
		reg_read(8'h48, d);
		check(d[21:0] === 22'h000000, "inhibit sources not inactive");
		di_req <= 16'hffff;
		settle();
		check(flag === 1'b0 && eff === 18'h00000, "selection without connected source");
		check(sp === 20'h00000 && pos_clamped === 1'b0 && neg_clamped === 1'b0, "direction blocked");
		di_req <= 16'h0000;
	endtask : test_reset

	task automatic test_direct();
		logic [31:0] d;
		int s;
		preset[1] = 300;
		preset[2] = 2000;
		preset[3] = -100;
		preset[4] = 7;
		for (int i = 1; i < 5; i++) begin
			reg_write(8'(4 * i), {16'h0000, 16'(preset[i])});
		end
		reg_read(8'h0c, d);
		check(d === 32'h0000ff9c, "preset readback");
		reg_write(8'h44, {8'h00, 6'h23, 6'h22, 6'h21, 6'h20});
		for (int c = 0; c < 16; c++) begin
			di_req <= 16'(c);
			settle();
			s = 0;
			for (int k = 0; k < 4; k++) begin
				if (c[k]) s += preset[k + 1];
			end
			check(eff === s[17:0], "direct sum");
			check(flag === (c != 0), "selected flag");
			check(sp === s[19:0], "main path from fixed speed");
		end
		di_req <= 16'h0004;
		settle();
		reg_read(8'h50, d);
		check(d === 32'hffffff9c, "effective readback");
		reg_read(8'h4c, d);
		check(d[0] === 1'b1, "status flag readback");
		reg_write(8'h48, 32'h05000000);
		settle();
		check(sp === 20'hfff38, "main plus additional fixed speed");
	endtask : test_direct

	task automatic test_binary();
		logic [31:0] d;
		int e;
		reg_write(8'h40, 32'h00000002);
		reg_write(8'h40, 32'h00000003);
		reg_read(8'h40, d);
		check(d === 32'h00000002, "mode write of 3 taken");
		reg_write(8'h00, 32'h00001234);
		preset[0] = 0;
		for (int i = 1; i < 16; i++) begin
			preset[i] = i * 100 - 700;
			reg_write(8'(4 * i), {16'h0000, 16'(preset[i])});
		end
		for (int c = 0; c < 16; c++) begin
			di_req <= 16'(c);
			settle();
			e = preset[c];
			check(eff === e[17:0], "binary pick");
			check(flag === (c != 0), "binary flag");
		end
	endtask : test_binary

	task automatic test_direction();
		int s;
		logic pc;
		logic nc;
		logic [15:0] cw;
		logic [31:0] d;
		di_req <= 16'h000c;
		reg_write(8'h48, {4'h0, 2'h2, 2'h1, 2'h0, 6'h36, 2'h0, 6'h35, 2'h0, 6'h3b});
		for (int v = 0; v < 2; v++) begin
			for (int k = 0; k < 8; k++) begin
				cw = 16'h0000;
				cw[11] = k[0];
				cw[5] = k[1];
				cw[6] = k[2];
				cw_req <= cw;
				extra_ext_in <= v ? 16'sd200 : -16'sd800;
				settle();
				s = v ? 700 : -300;
				if (k[0]) s = -s;
				pc = k[1] && s > 0;
				nc = k[2] && s < 0;
				if (pc || nc) s = 0;
				check(sp === s[19:0], "inverted or clamped setpoint");
				check(pos_clamped === pc, "positive inhibit");
				check(neg_clamped === nc, "negative inhibit");
			end
		end
		cw_req <= 16'h0000;
		extra_ext_in <= -16'sd800;
		reg_write(8'h48, {4'h0, 2'h2, 2'h1, 2'h0, 6'h10, 16'h0000});
		settle();
		check(sp === 20'h00000 && neg_clamped === 1'b1, "constant negative inhibit");
		// External main input alone, inverted from control word bit 11
		reg_write(8'h48, {4'h0, 2'h0, 2'h2, 2'h0, 6'h00, 2'h0, 6'h00, 2'h0, 6'h3b});
		main_ext_in <= 16'sd1234;
		cw_req <= 16'h0800;
		settle();
		check(sp === -20'sd1234, "external main setpoint inverted");
		reg_read(8'h54, d);
		check(d === 32'hfffffb2e, "setpoint readback");
		reg_read(8'h4c, d);
		check(d[1] === 1'b1, "invert status readback");
		cw_req <= 16'h0000;
		settle();
		check(sp === 20'sd1234, "external main setpoint passed");
		main_ext_in <= 16'sd0;
	endtask : test_direction

	// ----------------------------------------
	// Verdict and run control
	// ----------------------------------------
	task automatic results();
		$display("Checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results

	initial begin
		repeat (6000) @(posedge sys_clk);
		mismatches++;
		$display("[ERR] %0t watchdog expired", $time);
		results();
	end

	initial begin
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		test_reset();
		test_direct();
		test_binary();
		test_direction();
		results();
	end
endmodule : fixed_setpoint_selector_tb_top
